// *** design/sdio_discrete_io.v ***
// Discrete judgment, ready and busy outputs with mode-switched control inputs
//
// Functional notes
// - Three separate outputs report the high, pass and low result.
// - Low if below low threshold, high if above high, else pass (inclusive).
// - Ready is high while measurement is possible and drives the ready lamp.
// - Ready drops on light error, range over, head absent or config mode.
// - Busy is high while sampling with the hold function enabled.
// - Busy is also high for the whole of a bank switch.
// - A mode bit swaps inputs 1 and 2 between trigger/reset and bank A/B.
// - The reset input aborts measurement in progress and clears ready and busy.
// - While reset is held, judgments take the non-measurement levels.
// - Reset during hold use restores the state from before the hold was set.
// - Laser-off stops laser emission and flags a light amount error.
// - While laser-off is held, judgments take the non-measurement levels.
// - The zero reset input both executes and clears a zero reset.
// - In bank mode the two bank inputs give the bank number to switch to.
`timescale 1ns/1ps
`include "sdio_consts.vh"

module sdio_discrete_io (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire trigger_or_bank_a_in,
    input wire reset_or_bank_b_in,
    input wire laser_off_in,
    input wire zero_reset_in,
    output reg judge_high_out,
    output reg judge_pass_out,
    output reg judge_low_out,
    output reg ready_out,
    output reg busy_out,
    output reg laser_on_out
);

    // Two-stage synchronisers for the four pins; stage one is read only here
    // The delayed copy feeds the edge detectors; it resets to the idle pin
    // level so that no false edge follows reset
    wire [3:0] pin_raw;
    reg [3:0] sync1;
    reg [3:0] sync2;
    reg [3:0] sync2_d;
    assign pin_raw = {zero_reset_in, laser_off_in, reset_or_bank_b_in,
                      trigger_or_bank_a_in};
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sync1[gi] <= 1'b0;
                    sync2[gi] <= 1'b0;
                    sync2_d[gi] <= 1'b0;
                end else begin
                    sync1[gi] <= pin_raw[gi];
                    sync2[gi] <= sync1[gi];
                    sync2_d[gi] <= sync2[gi];
                end
            end
        end
    endgenerate

    // Software registers
    reg [`SDIO_CTRL_W-1:0] ctrl;
    reg [`SDIO_VAL_W-1:0] thr_high;
    reg [`SDIO_VAL_W-1:0] thr_low;
    reg [`SDIO_VAL_W-1:0] meas_val;
    reg meas_light_err;
    reg meas_range_over;
    reg meas_head_absent;
    reg [`SDIO_VAL_W-1:0] hold_len;
    reg meas_stb;

    // Block state
    reg zero_active;
    reg [`SDIO_VAL_W-1:0] zero_ref;
    reg sampling;
    reg [`SDIO_VAL_W-1:0] hold_cnt;
    reg [`SDIO_VAL_W-1:0] hold_last;
    reg [`SDIO_VAL_W-1:0] held_val;
    reg hold_valid;
    reg [1:0] bank;
    reg [1:0] bank_target;
    reg bank_sw;
    reg [`SDIO_BANK_CNT_W-1:0] bank_cnt;

    // Input roles follow the mode bit
    wire bank_mode = ctrl[`SDIO_CTRL_BANK_MODE];
    wire trig_rise = !bank_mode && sync2[0] && !sync2_d[0];
    wire rst_act = !bank_mode && sync2[1];
    wire laser_off = sync2[2];
    wire zr_rise = sync2[3] && !sync2_d[3];
    wire [1:0] bank_req = {sync2[1], sync2[0]};
    wire hold_en = ctrl[`SDIO_CTRL_HOLD_EN];

    // Laser-off overrides the head's own light report as a light error
    wire light_err = meas_light_err || laser_off;
    wire measurable = !light_err && !meas_range_over &&
                      !meas_head_absent && !ctrl[`SDIO_CTRL_CONFIG];

    // Value relative to the zero reference when one is active
    // Comparisons are signed: values below the reference go negative
    wire [`SDIO_VAL_W-1:0] live_val = zero_active ?
        meas_val - zero_ref : meas_val;
    wire [`SDIO_VAL_W-1:0] judge_val = hold_en ? held_val : live_val;
    wire have_val = !hold_en || hold_valid;
    wire is_low = $signed(judge_val) < $signed(thr_low);
    wire is_high = $signed(judge_val) > $signed(thr_high);

    // APB decode; the slave answers with no wait state
    // Ready rises on the first edge after reset and stays high
    wire apb_setup = psel && !penable;
    wire apb_wr = psel && penable && pwrite;
    wire hit = (paddr == `SDIO_OFS_CTRL) || (paddr == `SDIO_OFS_THR_HIGH) ||
               (paddr == `SDIO_OFS_THR_LOW) || (paddr == `SDIO_OFS_MEAS) ||
               (paddr == `SDIO_OFS_HOLD_LEN) || (paddr == `SDIO_OFS_STATUS) ||
               (paddr == `SDIO_OFS_ZERO_REF);
    wire read_only = (paddr == `SDIO_OFS_STATUS) ||
                     (paddr == `SDIO_OFS_ZERO_REF);
    wire [31:0] status_word = {20'h00000, hold_valid, sampling, bank,
                               zero_active, light_err, laser_on_out,
                               busy_out, ready_out, judge_low_out,
                               judge_pass_out, judge_high_out};
    reg [31:0] next_rdata;

    // Read mux, captured in the setup cycle so prdata is a flop
    // Latching in setup costs a flop stage but keeps the answer free of
    // wait states and the read path short
    always @* begin
        next_rdata = `SDIO_DATA_ZERO;
        case (paddr)
            `SDIO_OFS_CTRL: next_rdata = {26'h0000000, ctrl};
            `SDIO_OFS_THR_HIGH: next_rdata = {16'h0000, thr_high};
            `SDIO_OFS_THR_LOW: next_rdata = {16'h0000, thr_low};
            `SDIO_OFS_MEAS: next_rdata = {13'h0000, meas_head_absent,
                                          meas_range_over, meas_light_err,
                                          meas_val};
            `SDIO_OFS_HOLD_LEN: next_rdata = {16'h0000, hold_len};
            `SDIO_OFS_STATUS: next_rdata = status_word;
            `SDIO_OFS_ZERO_REF: next_rdata = {16'h0000, zero_ref};
            default: next_rdata = `SDIO_DATA_ZERO;
        endcase
    end

    // Bus slave and writable registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= `SDIO_DATA_ZERO;
            pready <= 1'b0;
            pslverr <= 1'b0;
            ctrl <= `SDIO_CTRL_RST;
            thr_high <= `SDIO_THR_HIGH_RST;
            thr_low <= `SDIO_THR_LOW_RST;
            meas_val <= `SDIO_VAL_RST;
            meas_light_err <= 1'b0;
            meas_range_over <= 1'b0;
            meas_head_absent <= 1'b0;
            hold_len <= `SDIO_HOLD_LEN_RST;
            meas_stb <= 1'b0;
        end else begin
            pready <= 1'b1;
            meas_stb <= 1'b0;
            if (apb_setup) begin
                prdata <= hit ? next_rdata : `SDIO_DATA_ZERO;
                pslverr <= !hit || (pwrite && read_only);
            end
            if (apb_wr && hit) begin
                case (paddr)
                    `SDIO_OFS_CTRL: ctrl <= pwdata[`SDIO_CTRL_W-1:0];
                    `SDIO_OFS_THR_HIGH: thr_high <= pwdata[`SDIO_VAL_W-1:0];
                    `SDIO_OFS_THR_LOW: thr_low <= pwdata[`SDIO_VAL_W-1:0];
                    `SDIO_OFS_MEAS: begin
                        // Each write is one new sample from the head
                        meas_val <= pwdata[`SDIO_VAL_W-1:0];
                        meas_light_err <= pwdata[`SDIO_MEAS_LIGHT_ERR];
                        meas_range_over <= pwdata[`SDIO_MEAS_RANGE_OVER];
                        meas_head_absent <= pwdata[`SDIO_MEAS_HEAD_ABSENT];
                        meas_stb <= 1'b1;
                    end
                    `SDIO_OFS_HOLD_LEN: hold_len <= pwdata[`SDIO_VAL_W-1:0];
                    default: meas_stb <= 1'b0;
                endcase
            end
        end
    end

    // Zero reset toggles on each rising edge of its input
    // The reference is the raw value, so a new zero reset never stacks
    // on top of an earlier offset
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            zero_active <= 1'b0;
            zero_ref <= `SDIO_VAL_RST;
        end else if (zr_rise) begin
            if (!zero_active) begin
                zero_active <= 1'b1;
                zero_ref <= meas_val;
            end else begin
                zero_active <= 1'b0;
            end
        end
    end

    // Hold sampling window opened by the trigger, aborted by reset
    // Limitation: trigger edges inside an open window are ignored, so a
    // fast self-trigger loses edges and each busy pulse keeps the set length
    // A length of zero or one still gives a one-cycle window
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sampling <= 1'b0;
            hold_cnt <= `SDIO_VAL_RST;
            hold_last <= `SDIO_VAL_RST;
            held_val <= `SDIO_VAL_RST;
            hold_valid <= 1'b0;
        end else if (rst_act || !hold_en) begin
            // Dropping the held value brings back the pre-hold state
            sampling <= 1'b0;
            hold_cnt <= `SDIO_VAL_RST;
            hold_valid <= 1'b0;
        end else if (trig_rise && !sampling) begin
            sampling <= 1'b1;
            hold_cnt <= hold_len;
            hold_last <= live_val;
        end else if (sampling) begin
            if (meas_stb) begin
                hold_last <= live_val;
            end
            if (hold_cnt <= 16'h0001) begin
                sampling <= 1'b0;
                held_val <= meas_stb ? live_val : hold_last;
                hold_valid <= 1'b1;
            end else begin
                hold_cnt <= hold_cnt - 16'h0001;
            end
        end
    end

    // Load value for the switch counter, cut to the counter's width
    localparam [31:0] bank_load = `SDIO_BANK_CYC - 1;

    // Bank switch: busy for a fixed time, then the new bank takes effect
    // A request that moves during a switch waits until the switch ends
    // and is compared again, so the last level always wins
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bank <= 2'h0;
            bank_target <= 2'h0;
            bank_sw <= 1'b0;
            bank_cnt <= {`SDIO_BANK_CNT_W{1'b0}};
        end else if (bank_sw) begin
            if (bank_cnt == {`SDIO_BANK_CNT_W{1'b0}}) begin
                bank_sw <= 1'b0;
                bank <= bank_target;
            end else begin
                bank_cnt <= bank_cnt - 5'h01;
            end
        end else if (bank_mode && bank_req != bank) begin
            bank_sw <= 1'b1;
            bank_target <= bank_req;
            bank_cnt <= bank_load[`SDIO_BANK_CNT_W-1:0];
        end
    end

    // Output stage; every pin comes from a flop
    // Reset and laser-off win over any stored result, since the pins must
    // show the configured levels for as long as either is held
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            judge_high_out <= 1'b0;
            judge_pass_out <= 1'b0;
            judge_low_out <= 1'b0;
            ready_out <= 1'b0;
            busy_out <= 1'b0;
            laser_on_out <= 1'b0;
        end else begin
            laser_on_out <= !laser_off;
            ready_out <= measurable && !rst_act;
            busy_out <= !rst_act &&
                        ((sampling && hold_en) || bank_sw);
            if (rst_act || laser_off || !measurable || !have_val) begin
                // No valid measurement: use the configured levels
                judge_high_out <= ctrl[`SDIO_CTRL_NM_HIGH];
                judge_pass_out <= ctrl[`SDIO_CTRL_NM_PASS];
                judge_low_out <= ctrl[`SDIO_CTRL_NM_LOW];
            end else begin
                judge_high_out <= is_high;
                judge_pass_out <= !is_high && !is_low;
                judge_low_out <= is_low;
            end
        end
    end

endmodule // sdio_discrete_io

// *** design/sdio_consts.vh ***
// Constants for the sensor discrete I/O logic: offsets, fields, timing
`ifndef SDIO_CONSTS_VH
`define SDIO_CONSTS_VH

// Register byte offsets
`define SDIO_ADDR_W 12
`define SDIO_OFS_CTRL 12'h000
`define SDIO_OFS_THR_HIGH 12'h004
`define SDIO_OFS_THR_LOW 12'h008
`define SDIO_OFS_MEAS 12'h00c
`define SDIO_OFS_HOLD_LEN 12'h010
`define SDIO_OFS_STATUS 12'h014
`define SDIO_OFS_ZERO_REF 12'h018

// Control register fields
`define SDIO_CTRL_BANK_MODE 0
`define SDIO_CTRL_CONFIG 1
`define SDIO_CTRL_HOLD_EN 2
`define SDIO_CTRL_NM_HIGH 3
`define SDIO_CTRL_NM_PASS 4
`define SDIO_CTRL_NM_LOW 5
`define SDIO_CTRL_W 6
`define SDIO_CTRL_RST 6'h00

// Measurement register fields: value in [15:0], condition flags above
`define SDIO_MEAS_LIGHT_ERR 16
`define SDIO_MEAS_RANGE_OVER 17
`define SDIO_MEAS_HEAD_ABSENT 18

// Reset values
`define SDIO_VAL_W 16
`define SDIO_VAL_RST 16'h0000
`define SDIO_THR_HIGH_RST 16'h0000
`define SDIO_THR_LOW_RST 16'h0000
`define SDIO_HOLD_LEN_RST 16'h0010
`define SDIO_DATA_ZERO 32'h00000000

// Bank switch: busy time in cycles of the 125 MHz clock
`define SDIO_BANK_SW_NS 128
`define SDIO_CLK_NS 8
`define SDIO_BANK_CNT_W 5
`define SDIO_BANK_CYC (`SDIO_BANK_SW_NS / `SDIO_CLK_NS)

`endif

// *** tb/sdio_plc_model.sv ***
// Far-side controller model driving the four discrete input pins
`timescale 1ns/1ps
module sdio_plc_model (
    input wire pclk,
    input wire [3:0] cmd,
    output reg trigger_or_bank_a_in,
    output reg reset_or_bank_b_in,
    output reg laser_off_in,
    output reg zero_reset_in
);
    // Levels move just after an edge; the block's synchronisers hide skew
    initial begin
        {zero_reset_in, laser_off_in, reset_or_bank_b_in} = 3'h0;
        trigger_or_bank_a_in = 1'b0;
    end
    // Bank number is the pair of pin levels, trigger is a plain level
    always @(posedge pclk) begin
        trigger_or_bank_a_in <= cmd[0];
        reset_or_bank_b_in <= cmd[1];
        laser_off_in <= cmd[2];
        zero_reset_in <= cmd[3];
    end
endmodule // sdio_plc_model

// *** tb/sdio_discrete_io_asserts.sv ***
// Checker for bus answers, reset quiet and laser-off at the block ports
`timescale 1ns/1ps
module sdio_chk (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire laser_off_in,
    input wire judge_pass_out,
    input wire ready_out,
    input wire busy_out,
    input wire laser_on_out
);
    // Reset quiet is checked without a disable, so it sees reset itself
    chk_reset_quiet: assert property (@(posedge pclk) !presetn |->
        !pready && !ready_out && !busy_out && !laser_on_out && !judge_pass_out)
        else $error("output active during reset");
    chk_ready_always: assert property (@(posedge pclk) disable iff (!presetn)
        $past(presetn) |-> pready) else $error("pready low out of reset");
    chk_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable && paddr > 12'h018 |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    chk_ro_write: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable && pwrite && (paddr == 12'h014 || paddr == 12'h018)
        |=> pslverr) else $error("read-only write not refused");
    chk_mapped_ok: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable && !pwrite && paddr <= 12'h018 && paddr[1:0] == 2'h0
        |=> !pslverr) else $error("mapped read refused");
    chk_rdata_stands: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && pready |=> $stable(prdata))
        else $error("read data moved after access");
    chk_laser_stop: assert property (
        @(posedge pclk) disable iff (!presetn)
        laser_off_in [*6] |-> !laser_on_out && !ready_out)
        else $error("laser or ready on under laser-off");
    chk_laser_back: assert property (
        @(posedge pclk) disable iff (!presetn)
        !laser_off_in [*6] |-> laser_on_out)
        else $error("laser off without laser-off pin");
endmodule // sdio_chk

// *** tb/tb.sv ***
// Self-checking bench for the discrete I/O block over APB and pins
`timescale 1ns/1ps
`include "sdio_consts.vh"
module tb;
    logic pclk = 1'b0, presetn, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, perr;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rdat;
    logic [3:0] cmd = 4'h0;
    wire [31:0] prdata;
    wire pready, pslverr, judge_high_out, judge_pass_out, judge_low_out;
    wire ready_out, busy_out, laser_on_out, trigger_or_bank_a_in;
    wire reset_or_bank_b_in, laser_off_in, zero_reset_in;
    wire [2:0] jdg = {judge_high_out, judge_pass_out, judge_low_out};
    logic [15:0] mv [4] = '{16'hfff5, 16'hfff6, 16'h000a, 16'h000b};
    logic [2:0] je [4] = '{3'h1, 3'h2, 3'h2, 3'h4};
    int n_mismatch = 0, checks_done = 0, i, n;
    sdio_discrete_io uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .trigger_or_bank_a_in(trigger_or_bank_a_in),
        .reset_or_bank_b_in(reset_or_bank_b_in), .laser_off_in(laser_off_in),
        .zero_reset_in(zero_reset_in), .judge_high_out(judge_high_out),
        .judge_pass_out(judge_pass_out), .judge_low_out(judge_low_out),
        .ready_out(ready_out), .busy_out(busy_out),
        .laser_on_out(laser_on_out));
    sdio_plc_model plc (.pclk(pclk), .cmd(cmd),
        .trigger_or_bank_a_in(trigger_or_bank_a_in),
        .reset_or_bank_b_in(reset_or_bank_b_in), .laser_off_in(laser_off_in),
        .zero_reset_in(zero_reset_in));
    // Clock at 125 MHz
    initial begin
        forever #4 pclk = ~pclk;
    end
    task complete_run();
        if (n_mismatch == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One APB transfer; waits on pready, never on a cycle count
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rd(input logic [11:0] a, input logic [31:0] exp, input string nm);
        apb(1'b0, a, 32'h0);
        chk(rdat, exp, nm);
    endtask
    // Pin to output takes about four edges through the synchronisers
    task settle();
        repeat (6) @(posedge pclk);
    endtask
    // Length of the next busy pulse, bounded on both ends
    task busy_len(output int c);
        c = 0;
        for (int k = 0; k < 20 && busy_out !== 1'b1; k++) @(posedge pclk);
        while (busy_out === 1'b1 && c < 40) begin
            @(posedge pclk);
            c++;
        end
    endtask
    // Hang guard, well above the few hundred cycles the run needs
    initial begin
        #200000;
        n_mismatch++;
        complete_run();
    end
    initial begin
        // Going from unknown to low gives the edge that resets the flops
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rd(`SDIO_OFS_CTRL, 32'h0, "ctrl");
        rd(`SDIO_OFS_HOLD_LEN, 32'h10, "hold_len");
        rd(`SDIO_OFS_STATUS, 32'h2a, "status");
        rd(12'h020, 32'h0, "unmapped");
        chk(perr, 32'h1, "unmapped err");
        apb(1'b1, `SDIO_OFS_STATUS, 32'hffff);
        chk(perr, 32'h1, "ro err");
        // Threshold edges, signed and inclusive
        apb(1'b1, `SDIO_OFS_THR_LOW, 32'hfff6);
        apb(1'b1, `SDIO_OFS_THR_HIGH, 32'h000a);
        for (i = 0; i < 4; i++) begin
            apb(1'b1, `SDIO_OFS_MEAS, {16'h0, mv[i]});
            settle();
            chk(32'(jdg), 32'(je[i]), "judge");
        end
        // Each unmeasurable cause, with non-measurement level low only, except config mode with high and pass
        apb(1'b1, `SDIO_OFS_CTRL, 32'h20);
        for (i = 16; i < 19; i++) begin
            apb(1'b1, `SDIO_OFS_MEAS, 32'h1 << i);
            settle();
            chk(32'(ready_out), 32'h0, "ready cause");
            chk(32'(jdg), 32'h1, "judge nonmeas");
        end
        apb(1'b1, `SDIO_OFS_MEAS, 32'h0);
        apb(1'b1, `SDIO_OFS_CTRL, 32'h1a);
        settle();
        chk(32'(ready_out), 32'h0, "ready config");
        chk(32'(jdg), 32'h6, "judge config");
        apb(1'b1, `SDIO_OFS_CTRL, 32'h20);
        settle();
        chk(32'(ready_out), 32'h1, "ready back");
        chk(32'(jdg), 32'h2, "judge back");
        cmd <= 4'h4;
        settle();
        chk(32'(laser_on_out), 32'h0, "laser");
        chk(32'(jdg), 32'h1, "judge laser off");
        rd(`SDIO_OFS_STATUS, 32'h44, "status laser off");
        cmd <= 4'h2;
        settle();
        chk(32'(ready_out), 32'h0, "ready reset pin");
        chk(32'(jdg), 32'h1, "judge reset pin");
        cmd <= 4'h0;
        // Hold: no held value yet, then trigger opens an 8-cycle window
        apb(1'b1, `SDIO_OFS_HOLD_LEN, 32'h8);
        apb(1'b1, `SDIO_OFS_CTRL, 32'h24);
        apb(1'b1, `SDIO_OFS_MEAS, 32'h000b);
        settle();
        chk(32'(jdg), 32'h1, "judge no hold");
        cmd <= 4'h1;
        busy_len(n);
        chk(n, 32'h8, "busy hold");
        settle();
        chk(32'(jdg), 32'h4, "judge held");
        cmd <= 4'h3;
        settle();
        cmd <= 4'h0;
        settle();
        chk(32'(jdg), 32'h1, "judge hold dropped");
        // Bank mode: reset pin becomes bank B, each switch is busy
        apb(1'b1, `SDIO_OFS_CTRL, 32'h01);
        for (i = 1; i < 4; i++) begin
            cmd <= 4'(i);
            busy_len(n);
            chk(n, `SDIO_BANK_CYC, "busy bank");
            settle();
            rd(`SDIO_OFS_STATUS, 32'h29 | (i << 8), "status read");
            chk(32'(rdat[9:8]), i, "bank");
            chk(32'(ready_out), 32'h1, "ready bank mode");
        end
        // Zero reset toggles on rising edges
        apb(1'b1, `SDIO_OFS_CTRL, 32'h0);
        cmd <= 4'h0;
        apb(1'b1, `SDIO_OFS_MEAS, 32'h64);
        settle();
        chk(32'(jdg), 32'h4, "judge raw");
        cmd <= 4'h8;
        settle();
        rd(`SDIO_OFS_ZERO_REF, 32'h64, "zero ref");
        chk(32'(jdg), 32'h2, "judge zeroed");
        cmd <= 4'h0;
        settle();
        cmd <= 4'h8;
        settle();
        chk(32'(jdg), 32'h4, "judge unzeroed");
        complete_run();
    end
endmodule // tb
bind sdio_discrete_io sdio_chk chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .laser_off_in(laser_off_in), .judge_pass_out(judge_pass_out),
    .ready_out(ready_out), .busy_out(busy_out), .laser_on_out(laser_on_out));
